// ---- hw/sts_pkg.sv ----
package sts_pkg;

  // ***********************************************************
  // register map of the control port
  // ***********************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FEAT_LO = 8'h04;
  localparam logic [7:0] ADDR_FEAT_HI = 8'h08;
  localparam logic [7:0] ADDR_VCS = 8'h0C;
  localparam logic [7:0] ADDR_INUSE_LO = 8'h10;
  localparam logic [7:0] ADDR_INUSE_HI = 8'h14;
  localparam logic [7:0] ADDR_CHG_LO = 8'h18;
  localparam logic [7:0] ADDR_CHG_HI = 8'h1C;
  localparam logic [7:0] ADDR_STATUS = 8'h20;

  // control register fields
  localparam int unsigned CTRL_OS_EN = 0;
  localparam int unsigned CTRL_MODE64 = 1;
  localparam int unsigned CTRL_TRACK = 2;
  localparam int unsigned CTRL_TS = 3;
  localparam logic [3:0] CTRL_RST = 4'h4;
  localparam logic [63:0] FEAT_RST = 64'h0000_0000_0000_0003;
  localparam logic [31:0] VCS_RST = 32'h0000_1F80;

  // ***********************************************************
  // initial-configuration values and save-area layout
  // ***********************************************************
  localparam logic [15:0] FCW_INIT = 16'h037F;
  localparam logic [15:0] FSW_INIT = 16'h0000;
  localparam logic [15:0] FTW_INIT = 16'hFFFF;
  localparam logic [15:0] SEL_INIT = 16'h0000;
  localparam int unsigned NTRACK = 10;
  localparam logic [63:0] HDR_OFF = 64'h0000_0000_0000_0200;
  localparam logic [5:0] ALIGN_LOW = 6'h00;
  localparam logic [5:0] LAST_COMP = 6'h3E;
  localparam logic [5:0] COMP_SSE = 6'h01;
  localparam logic [5:0] COMP_AVX = 6'h02;
  localparam logic [31:0] SEL_FEAT = 32'h0000_0000;
  localparam logic [31:0] SEL_INUSE = 32'h0000_0001;

  typedef enum logic [2:0] {
    OP_NONE, OP_RESTORE, OP_PLAIN_SAVE, OP_OPT_SAVE, OP_COMPACT_SAVE, OP_SUP_SAVE, OP_XREAD
  } sts_op_e;

  typedef enum logic [1:0] {FLT_NONE, FLT_UD, FLT_NM, FLT_GP} sts_fault_e;

  typedef enum logic [2:0] {S_IDLE, S_HDR_RD, S_HDR_DATA, S_COMP, S_DONE} sts_state_e;

  typedef struct packed {
    logic valid;
    sts_op_e op;
    logic [31:0] sel;
    logic [63:0] mask;
    logic [63:0] area_addr;
    logic [1:0] current_privilege_level;
    logic nonroot;
    logic [63:0] comp_bv;
    logic [63:0] state_bv;
  } sts_cmd_s;

  typedef struct packed {
    logic [15:0] fp_control_word, fp_status_word, fp_tag_word, fcs, fds;
    logic fip_zero, fdp_zero;
    logic [7:0] st_zero;
    logic [15:0] xmm_zero, ymmh_zero, zmmh_zero, hi16_zero;
    logic [3:0] bnd_zero;
    logic bndcfg_zero, bndsts_zero;
    logic [7:0] k_zero;
    logic [8:0] pt_zero;
    logic protection_key_rights_zero;
  } sts_regsum_s;

  typedef struct packed {
    logic done;
    sts_fault_e fault;
    logic [63:0] data;
  } sts_rsp_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [63:0] addr;
    logic [63:0] wdata;
  } sts_mem_s;

  typedef struct packed {
    logic valid;
    logic [5:0] idx;
    logic legacy;
    logic vcs;
  } sts_store_s;

endpackage : sts_pkg

// ---- hw/sts_tracker.sv ----
// Notes on behaviour
// (RULE1) other saves may skip initial components
// (RULE2) same-area saves may skip unmodified components
// (RULE3) plain save never skips; compacted skips initial
// (RULE4) no tracking means both bitmaps all ones
// (RULE5) in-use zero only when component known initial
// (RULE6) selector-1 read returns feature mask AND in-use
// (RULE7) bit 1 forced when vector status not reset
// (RULE8) changed zero only when unchanged since restore
// (RULE9) restore records privilege, non-root, address, compaction
// (RULE10) unmodified skip needs all four context items equal
// (RULE11) floating-point stack initial values defined
// (RULE12) 128-bit vectors initial per mode, ignoring status
// (RULE13) 256-bit upper halves initial per mode
// (RULE14) bounds, bounds config, mask registers initial when zero
// (RULE15) 512-bit halves per mode; high sixteen initial outside
// (RULE16) trace and protection-key components initial when zero
// (RULE17) plain save faults: disabled, task switched, misaligned
// (RULE18) requested bitmap is feature mask AND operand
// (RULE19) header bitmap merged with in-use under request
// (RULE20) plain save writes only the header state bitmap
// (RULE21) store requested components, legacy then standard extended
// (RULE22) vector status stored when request bit 1 or 2
// (RULE23) writing non-initial value sets in-use and changed
`timescale 1ns/1ps
`default_nettype none

module sts_tracker (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire sts_pkg::sts_cmd_s cmd,
  input wire logic [63:0] state_write,
  input wire sts_pkg::sts_regsum_s regsum,
  input wire logic [63:0] mem_rdata,
  output var sts_pkg::sts_rsp_s rsp,
  output var sts_pkg::sts_mem_s mem_req,
  output var sts_pkg::sts_store_s store,
  output logic busy
);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // ***********************************************************
  // control registers
  // ***********************************************************
  logic [3:0] ctrl;
  logic [63:0] feat, in_use, changed;
  logic [31:0] vcs;
  sts_pkg::sts_fault_e last_fault;
  sts_pkg::sts_state_e state;
  wire os_en = ctrl[sts_pkg::CTRL_OS_EN];
  wire mode64 = ctrl[sts_pkg::CTRL_MODE64];
  wire track = ctrl[sts_pkg::CTRL_TRACK];
  wire ts_flag = ctrl[sts_pkg::CTRL_TS];
  // address decode for writes
  wire wr_ctrl = reg_wr && (reg_addr == sts_pkg::ADDR_CTRL);
  wire wr_flo = reg_wr && (reg_addr == sts_pkg::ADDR_FEAT_LO);
  wire wr_fhi = reg_wr && (reg_addr == sts_pkg::ADDR_FEAT_HI);
  wire wr_vcs = reg_wr && (reg_addr == sts_pkg::ADDR_VCS);
  wire [31:0] status_word = {27'h0000000, last_fault, 2'h0, busy};

  // read mux; unmapped addresses read as zero
  logic [31:0] next_rdata;
  always_comb begin
    if (reg_addr == sts_pkg::ADDR_CTRL) next_rdata = {28'h0000000, ctrl};
    else if (reg_addr == sts_pkg::ADDR_FEAT_LO) next_rdata = feat[31:0];
    else if (reg_addr == sts_pkg::ADDR_FEAT_HI) next_rdata = feat[63:32];
    else if (reg_addr == sts_pkg::ADDR_VCS) next_rdata = vcs;
    else if (reg_addr == sts_pkg::ADDR_INUSE_LO) next_rdata = in_use[31:0];
    else if (reg_addr == sts_pkg::ADDR_INUSE_HI) next_rdata = in_use[63:32];
    else if (reg_addr == sts_pkg::ADDR_CHG_LO) next_rdata = changed[31:0];
    else if (reg_addr == sts_pkg::ADDR_CHG_HI) next_rdata = changed[63:32];
    else if (reg_addr == sts_pkg::ADDR_STATUS) next_rdata = status_word;
    else next_rdata = 32'h00000000;
  end
  // read data stands only in the cycle after the read strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) reg_rdata <= 32'h00000000;
    else reg_rdata <= reg_rd ? next_rdata : 32'h00000000;
  end
  // software-written configuration steering the save path
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= sts_pkg::CTRL_RST;
      feat <= sts_pkg::FEAT_RST;
      vcs <= sts_pkg::VCS_RST;
    end else begin
      if (wr_ctrl) ctrl <= reg_wdata[3:0];
      if (wr_flo) feat[31:0] <= reg_wdata;
      if (wr_fhi) feat[63:32] <= reg_wdata;
      if (wr_vcs) vcs <= reg_wdata;
    end
  end

  // ***********************************************************
  // initial-configuration detection
  // ***********************************************************
  logic [sts_pkg::NTRACK-1:0] comp_init;
  assign comp_init[0] = (regsum.fp_control_word == sts_pkg::FCW_INIT) && (regsum.fp_status_word == sts_pkg::FSW_INIT)
    && (regsum.fp_tag_word == sts_pkg::FTW_INIT) && (regsum.fcs == sts_pkg::SEL_INIT)
    && (regsum.fds == sts_pkg::SEL_INIT) && regsum.fip_zero && regsum.fdp_zero
    && (&regsum.st_zero); // RULE11
  // the vector status word is deliberately left out of component 1
  assign comp_init[1] = mode64 ? &regsum.xmm_zero : &regsum.xmm_zero[7:0]; // RULE12
  assign comp_init[2] = mode64 ? &regsum.ymmh_zero : &regsum.ymmh_zero[7:0]; // RULE13
  assign comp_init[3] = &regsum.bnd_zero; // RULE14
  assign comp_init[4] = regsum.bndcfg_zero && regsum.bndsts_zero; // RULE14
  assign comp_init[5] = &regsum.k_zero; // RULE14
  assign comp_init[6] = mode64 ? &regsum.zmmh_zero : &regsum.zmmh_zero[7:0]; // RULE15
  assign comp_init[7] = mode64 ? &regsum.hi16_zero : 1'b1; // RULE15
  assign comp_init[8] = &regsum.pt_zero; // RULE16
  assign comp_init[9] = regsum.protection_key_rights_zero; // RULE16

  // ***********************************************************
  // command acceptance
  // ***********************************************************
  wire idle = (state == sts_pkg::S_IDLE);
  wire cmd_go = cmd.valid && idle;
  wire restore_go = cmd_go && (cmd.op == sts_pkg::OP_RESTORE);
  wire plain_go = cmd_go && (cmd.op == sts_pkg::OP_PLAIN_SAVE);
  wire [63:0] cmd_requested_component_bitmap = feat & cmd.mask; // RULE18

  // ***********************************************************
  // in-use and changed bitmaps
  // ***********************************************************
  // bits beyond the tracked components are held at one, which is
  // always safe: a one only costs a save that could have been skipped
  logic [63:0] next_in_use, next_changed;
  genvar gi;
  generate
    for (gi = 0; gi < 64; gi++) begin : g_track
      if (gi < sts_pkg::NTRACK) begin : g_on
        assign next_in_use[gi] = !track || state_write[gi] || !comp_init[gi]
          || (restore_go && cmd_requested_component_bitmap[gi] && cmd.state_bv[gi]); // RULE5 RULE23
        // a write in the same cycle as a restore wins over the clear
        assign next_changed[gi] = !track || state_write[gi]
          || (restore_go ? !cmd_requested_component_bitmap[gi] : changed[gi]); // RULE8 RULE23
      end else begin : g_off
        assign next_in_use[gi] = 1'b1; // RULE4
        assign next_changed[gi] = 1'b1; // RULE4
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_use <= {64{1'b1}};
      changed <= {64{1'b1}};
    end else begin
      in_use <= next_in_use;
      changed <= next_changed;
    end
  end

  // ***********************************************************
  // last restore context
  // ***********************************************************
  logic ctx_valid, ctx_nonroot;
  logic [1:0] ctx_cpl;
  logic [63:0] ctx_addr, ctx_comp;
  // every restore overwrites the context, even with tracking off
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctx_valid <= 1'b0;
      ctx_cpl <= 2'h0;
      ctx_nonroot <= 1'b0;
      ctx_addr <= 64'h0000_0000_0000_0000;
      ctx_comp <= 64'h0000_0000_0000_0000;
    end else if (restore_go) begin
      ctx_valid <= track; // RULE9
      ctx_cpl <= cmd.current_privilege_level;
      ctx_nonroot <= cmd.nonroot;
      ctx_addr <= cmd.area_addr;
      ctx_comp <= cmd.comp_bv;
    end
  end

  wire ctx_match = ctx_valid && (ctx_cpl == cmd.current_privilege_level) && (ctx_nonroot == cmd.nonroot)
    && (ctx_addr == cmd.area_addr) && (ctx_comp == cmd.comp_bv); // RULE10
  // ***********************************************************
  // skip bitmaps and extended-control read
  // ***********************************************************
  wire [63:0] init_skip = ~in_use & cmd_requested_component_bitmap; // RULE1
  wire [63:0] mod_skip = ctx_match ? (~changed & cmd_requested_component_bitmap) : 64'h0000_0000_0000_0000; // RULE2
  wire [63:0] opt_skip = init_skip | mod_skip;
  wire vcs_dirty = feat[1] && (vcs != sts_pkg::VCS_RST);
  wire [63:0] inuse_read = (feat & in_use) | {62'h0, vcs_dirty, 1'b0}; // RULE6 RULE7
  wire [63:0] xread_data = (cmd.sel == sts_pkg::SEL_INUSE) ? inuse_read
    : (cmd.sel == sts_pkg::SEL_FEAT) ? feat : 64'h0000_0000_0000_0000;
  // compacted save uses only the initial skip
  wire [63:0] quick_data = (cmd.op == sts_pkg::OP_COMPACT_SAVE) ? init_skip // RULE3
    : ((cmd.op == sts_pkg::OP_OPT_SAVE) || (cmd.op == sts_pkg::OP_SUP_SAVE)) ? opt_skip
    : (cmd.op == sts_pkg::OP_XREAD) ? xread_data : 64'h0000_0000_0000_0000;
  // fault priority: disabled, then task switched, then alignment
  wire sts_pkg::sts_fault_e plain_fault = !os_en ? sts_pkg::FLT_UD
    : ts_flag ? sts_pkg::FLT_NM
    : (cmd.area_addr[5:0] != sts_pkg::ALIGN_LOW) ? sts_pkg::FLT_GP : sts_pkg::FLT_NONE; // RULE17

  // ***********************************************************
  // plain save sequencer
  // ***********************************************************
  logic [63:0] requested_component_bitmap_q, area_q;
  logic [5:0] idx, next_idx;
  sts_pkg::sts_state_e next_state;
  sts_pkg::sts_rsp_s next_rsp;
  sts_pkg::sts_mem_s next_mem;
  sts_pkg::sts_store_s next_store;
  // header merge: untouched where not requested, in-use where requested
  wire [63:0] hdr_merge = (mem_rdata & ~requested_component_bitmap_q) | (in_use & requested_component_bitmap_q); // RULE19
  wire vcs_req = requested_component_bitmap_q[sts_pkg::COMP_SSE] || requested_component_bitmap_q[sts_pkg::COMP_AVX];
  always_comb begin
    next_state = state;
    next_idx = idx;
    next_rsp = '0;
    next_mem = '0;
    next_store = '0;
    case (state)
      sts_pkg::S_IDLE: begin
        if (plain_go) begin
          next_rsp.fault = plain_fault;
          if (plain_fault != sts_pkg::FLT_NONE) begin
            next_rsp.done = 1'b1;
          end else begin
            next_state = sts_pkg::S_HDR_RD;
            next_mem.rd = 1'b1;
            next_mem.addr = cmd.area_addr + sts_pkg::HDR_OFF;
          end
        end else if (cmd_go && (cmd.op != sts_pkg::OP_NONE)) begin
          next_rsp.done = 1'b1;
          next_rsp.data = quick_data;
        end
      end
      sts_pkg::S_HDR_RD: begin
        next_state = sts_pkg::S_HDR_DATA;
      end
      sts_pkg::S_HDR_DATA: begin
        // only the state bitmap word is written; compaction word untouched
        next_mem.wr = 1'b1; // RULE20
        next_mem.addr = area_q + sts_pkg::HDR_OFF;
        next_mem.wdata = hdr_merge;
        next_idx = 6'h00;
        next_state = sts_pkg::S_COMP;
      end
      sts_pkg::S_COMP: begin
        // one slot per component keeps timing fixed at the cost of idle slots
        next_store.vcs = (idx == sts_pkg::COMP_SSE) && vcs_req; // RULE22
        next_store.valid = requested_component_bitmap_q[idx] || next_store.vcs; // RULE3 RULE21
        next_store.idx = idx;
        next_store.legacy = (idx < sts_pkg::COMP_AVX); // RULE21
        next_idx = idx + 6'h01;
        if (idx == sts_pkg::LAST_COMP) next_state = sts_pkg::S_DONE;
      end
      sts_pkg::S_DONE: begin
        next_rsp.done = 1'b1;
        next_state = sts_pkg::S_IDLE;
      end
      default: next_state = sts_pkg::S_IDLE;
    endcase
  end

  // sequencer and answer registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= sts_pkg::S_IDLE;
      idx <= 6'h00;
      rsp <= '0;
      mem_req <= '0;
      store <= '0;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      idx <= next_idx;
      rsp <= next_rsp;
      mem_req <= next_mem;
      store <= next_store;
      busy <= (next_state != sts_pkg::S_IDLE);
    end
  end

  // operands captured when a plain save starts
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      requested_component_bitmap_q <= 64'h0000_0000_0000_0000;
      area_q <= 64'h0000_0000_0000_0000;
      last_fault <= sts_pkg::FLT_NONE;
    end else if (plain_go) begin
      requested_component_bitmap_q <= cmd_requested_component_bitmap; // RULE18
      area_q <= cmd.area_addr;
      last_fault <= plain_fault;
    end
  end

  // ***********************************************************
  // assertions
  // ***********************************************************
  property p_untracked_ones;
    in_use[63:sts_pkg::NTRACK] == '1 && changed[63:sts_pkg::NTRACK] == '1;
  endproperty
  a_untracked_ones: assert property (p_untracked_ones) // RULE4
    else $error("untracked bitmap bit dropped to zero");
  property p_no_track_ones;
    !track |=> (in_use == '1) && (changed == '1);
  endproperty
  a_no_track_ones: assert property (p_no_track_ones) // RULE4
    else $error("bitmaps not all ones with tracking off");
  property p_inuse_zero_init;
    ((~in_use[sts_pkg::NTRACK-1:0]) & ~$past(comp_init)) == '0;
  endproperty
  a_inuse_zero_init: assert property (p_inuse_zero_init) // RULE5
    else $error("in-use cleared for a non-initial component");
  property p_write_sets;
    (state_write != '0) |=> ((in_use & changed & $past(state_write)) == $past(state_write));
  endproperty
  a_write_sets: assert property (p_write_sets) // RULE23
    else $error("state write did not set tracking bits");
  property p_xread;
    (cmd_go && cmd.op == sts_pkg::OP_XREAD && cmd.sel == sts_pkg::SEL_INUSE)
      |=> rsp.done && rsp.data[0] == $past(feat[0] & in_use[0])
      && rsp.data[1] == $past((feat[1] & in_use[1]) | (feat[1] && vcs != sts_pkg::VCS_RST));
  endproperty
  a_xread: assert property (p_xread) // RULE7
    else $error("selector-1 read result wrong");
  property p_ctx_record;
    restore_go && track |=> ctx_valid && ctx_addr == $past(cmd.area_addr)
      && ctx_comp == $past(cmd.comp_bv) && ctx_cpl == $past(cmd.current_privilege_level);
  endproperty
  a_ctx_record: assert property (p_ctx_record) // RULE9
    else $error("restore context not recorded");
  property p_compact_skip;
    (cmd_go && cmd.op == sts_pkg::OP_COMPACT_SAVE)
      |=> rsp.data == $past(~in_use & feat & cmd.mask);
  endproperty
  a_compact_skip: assert property (p_compact_skip) // RULE3
    else $error("compacted save skip bitmap wrong");
  property p_plain_ud;
    plain_go && !os_en |=> rsp.done && rsp.fault == sts_pkg::FLT_UD && !mem_req.rd;
  endproperty
  a_plain_ud: assert property (p_plain_ud) // RULE17
    else $error("disabled save did not raise invalid opcode");
  sequence s_header_pass;
    mem_req.rd ##1 !mem_req.wr ##1 mem_req.wr;
  endsequence
  property p_plain_flow;
    plain_go && plain_fault == sts_pkg::FLT_NONE |=> s_header_pass;
  endproperty
  a_plain_flow: assert property (p_plain_flow) // RULE19
    else $error("header read and write-back out of order");
  property p_hdr_merge;
    mem_req.wr |-> mem_req.wdata == (($past(mem_rdata) & ~requested_component_bitmap_q) | ($past(in_use) & requested_component_bitmap_q))
      && mem_req.addr == area_q + sts_pkg::HDR_OFF;
  endproperty
  a_hdr_merge: assert property (p_hdr_merge) // RULE20
    else $error("header write-back value or address wrong");
  property p_vcs_store;
    store.vcs |-> store.valid && store.idx == sts_pkg::COMP_SSE && vcs_req;
  endproperty
  a_vcs_store: assert property (p_vcs_store) // RULE22
    else $error("vector status stored without request");

endmodule : sts_tracker

`default_nettype wire

// ---- bench/sts_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module sts_mem_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire sts_pkg::sts_mem_s mem_req,
  output logic [63:0] mem_rdata
);
  // ****
  // header word of the save area
  // ****
  logic [63:0] hdr = '0;
  logic [63:0] wr_addr = '0;
  int wr_cnt = 0;

  // read data stand one cycle only; afterwards the bus toggles so a late sample is caught
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_rdata <= '0;
    end else if (mem_req.rd) begin
      mem_rdata <= hdr;
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end

  // plain always: the bench preloads hdr between saves
  always @(posedge sys_clk) begin
    if (mem_req.wr) begin
      hdr <= mem_req.wdata;
      wr_addr <= mem_req.addr;
      wr_cnt <= wr_cnt + 1;
    end
  end
endmodule : sts_mem_model

`default_nettype wire

// ---- bench/test_state_tracking_and_save.sv ----
`timescale 1ns/1ps
`default_nettype none

module test_state_tracking_and_save;
  // ****
  // stimulus, expectations and verdict
  // ****
  localparam logic [63:0] INUSE = 64'hFFFF_FFFF_FFFF_FC21;
  localparam logic [63:0] AREA = 64'h0000_0000_0000_1000;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  sts_pkg::sts_cmd_s cmd = '0;
  logic [63:0] state_write = '0;
  sts_pkg::sts_regsum_s regsum = '1;
  logic [63:0] mem_rdata;
  sts_pkg::sts_rsp_s rsp;
  sts_pkg::sts_mem_s mem_req;
  sts_pkg::sts_store_s store;
  logic busy;
  int failures = 0;
  int compares = 0;
  int seed = 84;
  int n, ns, nv, nl, nb, ni, w;
  logic [31:0] d;
  logic [63:0] q, m, f, a, h;

  sts_tracker i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd(cmd),
    .state_write(state_write), .regsum(regsum), .mem_rdata(mem_rdata), .rsp(rsp),
    .mem_req(mem_req), .store(store), .busy(busy)
  );

  sts_mem_model i_mem (
    .sys_clk(sys_clk), .rst_n(rst_n), .mem_req(mem_req), .mem_rdata(mem_rdata)
  );

  // free-running core clock
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  // stores expected: every requested slot, plus slot 1 when only bit 2 asks for vector status
  function automatic int exp_stores(input logic [63:0] r);
    exp_stores = $countones(r[62:0]) + int'(r[2] & ~r[1]);
  endfunction : exp_stores

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude

  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= dt;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] ad);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // answer is due exactly one cycle after the command is taken
  task automatic go(input sts_pkg::sts_op_e op, input logic [31:0] sel, input logic [63:0] mk,
                    input logic [63:0] ar, input logic [1:0] cp, input logic nr,
                    input logic [63:0] cb);
    @(posedge sys_clk);
    cmd <= '{1'b1, op, sel, mk, ar, cp, nr, cb, 64'h0};
    @(posedge sys_clk);
    cmd.valid <= 1'b0;
    #1 q = (rsp.done === 1'b1) ? rsp.data : 64'hBAD0_BAD0_BAD0_BAD0;
  endtask : go

  // bounded wait for completion while counting component stores
  task automatic save(input logic [63:0] mk, input logic [63:0] ar);
    go(sts_pkg::OP_PLAIN_SAVE, '0, mk, ar, 2'h3, 1'b0, '0);
    ns = 0;
    nv = 0;
    nl = 0;
    nb = 0;
    ni = 0;
    n = 0;
    while (rsp.done !== 1'b1 && n < 100) begin
      @(posedge sys_clk);
      #1 n++;
      ns += int'(store.valid === 1'b1);
      nv += int'(store.valid === 1'b1 && store.vcs === 1'b1);
      nl += int'(store.valid === 1'b1 && store.legacy === 1'b1);
      nb += int'(busy === 1'b1);
      // slot idx k is launched on the edge k+4 cycles after the command
      ni += int'(store.valid === 1'b1 && store.idx !== 6'(n - 3));
    end
    if (n >= 100) begin
      failures++;
      conclude();
    end
  endtask : save

  // main sequence
  initial begin
    regsum.fp_control_word = sts_pkg::FCW_INIT;
    regsum.fp_status_word = sts_pkg::FSW_INIT;
    regsum.fp_tag_word = sts_pkg::FTW_INIT;
    regsum.fcs = sts_pkg::SEL_INIT;
    regsum.fds = sts_pkg::SEL_INIT;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(sts_pkg::ADDR_CTRL);
    chk(d, 32'h0000_0004);
    rd(sts_pkg::ADDR_FEAT_LO);
    chk(d, 32'h0000_0003);
    rd(sts_pkg::ADDR_VCS);
    chk(d, 32'h0000_1F80);
    rd(8'hFC);
    chk(d, 32'h0000_0000);
    $display("reset test done");
    wr(sts_pkg::ADDR_CTRL, 32'h0000_0007);
    rd(sts_pkg::ADDR_INUSE_LO);
    chk(d, 32'hFFFF_FC00);
    rd(sts_pkg::ADDR_INUSE_HI);
    chk(d, 32'hFFFF_FFFF);
    @(posedge sys_clk);
    state_write <= 64'h0000_0000_0000_0008;
    rd(sts_pkg::ADDR_INUSE_LO);
    chk(d, 32'hFFFF_FC08);
    state_write <= '0;
    regsum.xmm_zero[8] <= 1'b0;
    regsum.hi16_zero[0] <= 1'b0;
    rd(sts_pkg::ADDR_INUSE_LO);
    chk(d, 32'hFFFF_FC82);
    wr(sts_pkg::ADDR_CTRL, 32'h0000_0005);
    rd(sts_pkg::ADDR_INUSE_LO);
    chk(d, 32'hFFFF_FC00);
    regsum.xmm_zero[8] <= 1'b1;
    regsum.hi16_zero[0] <= 1'b1;
    wr(sts_pkg::ADDR_CTRL, 32'h0000_0003);
    rd(sts_pkg::ADDR_INUSE_LO);
    chk(d, 32'hFFFF_FFFF);
    rd(sts_pkg::ADDR_CHG_LO);
    chk(d, 32'hFFFF_FFFF);
    wr(sts_pkg::ADDR_CTRL, 32'h0000_0007);
    $display("tracking test done");
    regsum.fp_control_word <= 16'h037E;
    go(sts_pkg::OP_XREAD, sts_pkg::SEL_INUSE, '0, '0, 2'h0, 1'b0, '0);
    chk(q, 64'h1);
    wr(sts_pkg::ADDR_VCS, 32'h0000_1F81);
    go(sts_pkg::OP_XREAD, sts_pkg::SEL_INUSE, '0, '0, 2'h0, 1'b0, '0);
    chk(q, 64'h3);
    wr(sts_pkg::ADDR_FEAT_LO, 32'h0000_0001);
    go(sts_pkg::OP_XREAD, sts_pkg::SEL_INUSE, '0, '0, 2'h0, 1'b0, '0);
    chk(q, 64'h1);
    go(sts_pkg::OP_XREAD, sts_pkg::SEL_FEAT, '0, '0, 2'h0, 1'b0, '0);
    chk(q, 64'h1);
    go(sts_pkg::OP_XREAD, 32'h0000_0002, '0, '0, 2'h0, 1'b0, '0);
    chk(q, 64'h0);
    go(sts_pkg::OP_NONE, '0, '0, '0, 2'h0, 1'b0, '0);
    chk(q, 64'hBAD0_BAD0_BAD0_BAD0);
    wr(sts_pkg::ADDR_VCS, 32'h0000_1F80);
    $display("read test done");
    regsum.k_zero[0] <= 1'b0;
    wr(sts_pkg::ADDR_FEAT_LO, 32'h0000_03FF);
    go(sts_pkg::OP_RESTORE, '0, '1, AREA, 2'h3, 1'b0, '0);
    state_write <= 64'h0000_0000_0000_0020;
    @(posedge sys_clk);
    state_write <= '0;
    rd(sts_pkg::ADDR_CHG_LO);
    chk(d, 32'hFFFF_FC20);
    for (int k = 0; k < 7; k++) begin
      go(k == 5 ? sts_pkg::OP_SUP_SAVE : k == 6 ? sts_pkg::OP_COMPACT_SAVE :
         sts_pkg::OP_OPT_SAVE, '0, '1, k == 3 ? AREA + 64 : AREA, k == 1 ? 2'h2 : 2'h3,
         k == 2, k == 4 ? 64'h8000_0000_0000_0000 : '0);
      chk(q, (k == 0 || k == 5) ? 64'h3DF : 64'h3DE);
    end
    // changed bits were cleared by the restore, so tracking off must raise them
    wr(sts_pkg::ADDR_CTRL, 32'h0000_0003);
    rd(sts_pkg::ADDR_CHG_LO);
    chk(d, 32'hFFFF_FFFF);
    $display("skip test done");
    for (int k = 0; k < 3; k++) begin
      wr(sts_pkg::ADDR_CTRL, k == 0 ? 32'h0000_000E : k == 1 ? 32'h0000_000F : 32'h0000_0007);
      w = i_mem.wr_cnt;
      save('1, 64'h0000_0000_0000_0041);
      chk({n[7:0], rsp.fault, 8'(i_mem.wr_cnt - w)}, {8'h00, 2'(k + 1), 8'h00});
      rd(sts_pkg::ADDR_STATUS);
      chk(d, {27'h0000000, 2'(k + 1), 3'h0});
    end
    for (int k = 0; k < 6; k++) begin
      f = {$random(seed), $random(seed)};
      m = k == 0 ? 64'h4 : k == 1 ? '1 : {$random(seed), $random(seed)};
      a = {$random(seed), $random(seed)} & ~64'h3F;
      h = {$random(seed), $random(seed)};
      if (k == 0) f = 64'h0000_0000_0000_0004;
      wr(sts_pkg::ADDR_FEAT_LO, f[31:0]);
      wr(sts_pkg::ADDR_FEAT_HI, f[63:32]);
      i_mem.hdr = h;
      w = i_mem.wr_cnt;
      save(m, a);
      q = f & m;
      chk({n[7:0], rsp.fault}, {8'h42, sts_pkg::FLT_NONE});
      chk(i_mem.hdr, (h & ~q) | (INUSE & q));
      chk(i_mem.wr_addr, a + sts_pkg::HDR_OFF);
      chk(8'(i_mem.wr_cnt - w), 8'h01);
      chk(ns, exp_stores(q));
      chk(nv, int'(q[1] | q[2]));
      chk(nl, $countones(q[1:0]) + int'(q[2] & ~q[1]));
      chk({ni[7:0], nb[7:0]}, {8'h00, 8'h41});
    end
    $display("plain save test done");
    conclude();
  end
endmodule : test_state_tracking_and_save

`default_nettype wire
